// file: gpib_pkg.sv
// constants, state types and timing for the instrument bus port
// Behaviour
// - attention low means command, high means data
// - data lines inverted, low is one
// - assert data valid only after settle, ready
// - release not-ready only when able to take
// - release not-accepted only after byte latched
// - end line marks last data byte
// - end with attention low requests poll
// - interface clear halts, unaddresses, stops serial poll
// - remote enable low means remote operation
// - service request held low while needed
package gpib_pkg;
  // ---------------------------------------------------------------
  // widths and timing
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int RX_W = DATA_W + 2;
  localparam int PIN_W = DATA_W + 7;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 100;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] SETTLE_LD = CNT_W'(SETTLE_CYC);
  // positions of the synchronised pins
  localparam int P_DAV = DATA_W;
  localparam int P_NRFD = DATA_W + 1;
  localparam int P_NDAC = DATA_W + 2;
  localparam int P_EOI = DATA_W + 3;
  localparam int P_ATN = DATA_W + 4;
  localparam int P_IFC = DATA_W + 5;
  localparam int P_REN = DATA_W + 6;
  // ---------------------------------------------------------------
  // state machines
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {A_IDLE, A_READY, A_ACK, A_DONE} acc_t;
  typedef enum logic [1:0] {S_IDLE, S_SET, S_DAV, S_REL} src_t;
endpackage : gpib_pkg

// file: pin_sync.sv
// two-flop synchroniser for the bus pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 15,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins in, stable copy out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } sync_t;
  sync_t s_reg;
  sync_t s_next;

  initial begin
    if (W < 1) $error("pin_sync width must be positive");
  end

  // first stage is read only by the second stage
  always_comb begin
    s_next.meta = d;
    s_next.stab = s_reg.meta;
  end

  // idle bus lines float high, so reset to all ones
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= {INIT, INIT};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.stab;
endmodule : pin_sync
`default_nettype wire

// file: two_entry_buf.sv
// two-entry buffer with registered out_data and out_valid, in_ready decoded from the count, and valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module two_entry_buf #(
  parameter int W = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // filling side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // draining side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0] cnt;
    logic vld;
  } buf_t;
  buf_t b_reg;
  buf_t b_next;
  logic push;
  logic pop;

  initial begin
    if (W < 1) $error("two_entry_buf width must be positive");
  end

  // head feeds the output; tail catches a word while the head stalls
  always_comb begin
    b_next = b_reg;
    push = in_valid && (b_reg.cnt != 2'h2);
    pop = out_ready && (b_reg.cnt != 2'h0);
    if (pop) begin
      b_next.head = b_reg.tail;
    end
    if (push) begin
      if (b_reg.cnt == 2'h0 || (pop && b_reg.cnt == 2'h1)) begin
        b_next.head = in_data;
      end else begin
        b_next.tail = in_data;
      end
    end
    b_next.cnt = b_reg.cnt + {1'b0, push} - {1'b0, pop};
    // valid kept in its own flop so the output is never a decode of the count
    b_next.vld = (b_next.cnt != 2'h0);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      b_reg <= '0;
    end else begin
      b_reg <= b_next;
    end
  end

  assign in_ready = (b_reg.cnt != 2'h2);
  assign out_valid = b_reg.vld;
  assign out_data = b_reg.head;

  full_stall_a: assert property (@(posedge clk) disable iff (!nrst)
    (b_reg.cnt == 2'h2) && !out_ready |=> (b_reg.cnt == 2'h2) && $stable(b_reg.head))
    else $error("buffer lost a word while stalled");
endmodule : two_entry_buf
`default_nettype wire

// file: gpib_instrument_port.sv
// instrument bus port: acceptor, source and management lines
`timescale 1ns/100ps
`default_nettype none
module gpib_instrument_port (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // data lines, open drain, inverted
  input wire logic [7:0] dio_in,
  output logic [7:0] dio_out,
  output logic [7:0] dio_oe_n,
  // handshake lines, open drain
  input wire logic dav_n_in,
  output logic dav_n_out,
  output logic dav_oe_n,
  input wire logic nrfd_n_in,
  output logic nrfd_n_out,
  output logic nrfd_oe_n,
  input wire logic ndac_n_in,
  output logic ndac_n_out,
  output logic ndac_oe_n,
  // end or identify, open drain
  input wire logic eoi_n_in,
  output logic eoi_n_out,
  output logic eoi_oe_n,
  // management lines
  input wire logic atn_n_in,
  input wire logic ifc_n_in,
  input wire logic ren_n_in,
  output logic srq_n_out,
  output logic srq_oe_n,
  // received bytes
  output logic [7:0] rx_data,
  output logic rx_cmd,
  output logic rx_end,
  output logic rx_valid,
  input wire logic rx_ready,
  // bytes to send
  input wire logic [7:0] tx_data,
  input wire logic tx_end,
  input wire logic tx_valid,
  output logic tx_ready,
  // addressing and status
  input wire logic set_listen,
  input wire logic set_talk,
  input wire logic set_spoll,
  input wire logic clr_addr,
  input wire logic srq_req,
  output logic listening,
  output logic talking,
  output logic spoll_on,
  output logic remote,
  output logic ppoll_req,
  output logic ifc_active
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    gpib_pkg::acc_t acc;
    gpib_pkg::src_t src;
    logic [gpib_pkg::CNT_W-1:0] cnt;
    logic lsn;
    logic tlk;
    logic spl;
    logic rem;
    logic ppr;
    logic ifca;
    logic txr;
    logic [gpib_pkg::RX_W-1:0] lat;
    logic push;
    logic drv;
    logic nrfd_oe_n;
    logic ndac_oe_n;
    logic dav_oe_n;
    logic eoi_oe_n;
    logic srq_oe_n;
    logic [7:0] dio_oe_n;
  } st_t;
  st_t r_reg;
  st_t r_next;

  logic [gpib_pkg::PIN_W-1:0] pins;
  logic [gpib_pkg::PIN_W-1:0] pin_h;
  logic [7:0] dio_h;
  logic dav_h;
  logic nrfd_h;
  logic ndac_h;
  logic eoi_h;
  logic atn_h;
  logic ifc_h;
  logic ren_h;
  logic part;
  logic [gpib_pkg::RX_W-1:0] rx_word;
  logic buf_in_ready;

  // ---------------------------------------------------------------
  // pin synchronisers and receive buffer
  // ---------------------------------------------------------------
  assign pins = {ren_n_in, ifc_n_in, atn_n_in, eoi_n_in, ndac_n_in,
                 nrfd_n_in, dav_n_in, dio_in};

  pin_sync #(.W(gpib_pkg::PIN_W), .INIT('1)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d(pins),
    .q(pin_h)
  );

  assign dio_h = pin_h[7:0];
  assign dav_h = pin_h[gpib_pkg::P_DAV];
  assign nrfd_h = pin_h[gpib_pkg::P_NRFD];
  assign ndac_h = pin_h[gpib_pkg::P_NDAC];
  assign eoi_h = pin_h[gpib_pkg::P_EOI];
  assign atn_h = pin_h[gpib_pkg::P_ATN];
  assign ifc_h = pin_h[gpib_pkg::P_IFC];
  assign ren_h = pin_h[gpib_pkg::P_REN];

  // a stalled reader fills the buffer, which then holds the bus off
  two_entry_buf #(.W(gpib_pkg::RX_W)) u_rxbuf (
    .clk(clk),
    .nrst(nrst),
    .in_data(r_reg.lat),
    .in_valid(r_reg.push),
    .in_ready(buf_in_ready),
    .out_data(rx_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // every device takes commands; data only when addressed to listen
  assign part = !atn_h || r_reg.lsn;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.push = 1'b0;
    r_next.drv = 1'b0;
    // management lines are plain levels, sampled every cycle
    r_next.rem = !ren_h;
    r_next.ppr = !atn_h && !eoi_h;
    r_next.srq_oe_n = !srq_req;
    r_next.ifca = !ifc_h;
    // addressing: talk and listen exclude each other
    if (clr_addr) begin
      r_next.lsn = 1'b0;
      r_next.tlk = 1'b0;
    end else if (set_listen) begin
      r_next.lsn = 1'b1;
      r_next.tlk = 1'b0;
    end else if (set_talk) begin
      r_next.tlk = 1'b1;
      r_next.lsn = 1'b0;
    end
    if (set_spoll) begin
      r_next.spl = 1'b1;
    end
    // acceptor handshake
    case (r_reg.acc)
      gpib_pkg::A_IDLE: begin
        r_next.nrfd_oe_n = !part;
        r_next.ndac_oe_n = !part;
        if (part && buf_in_ready && dav_h) begin
          r_next.nrfd_oe_n = 1'b1;
          r_next.acc = gpib_pkg::A_READY;
        end
      end
      gpib_pkg::A_READY: begin
        if (!part) begin
          r_next.acc = gpib_pkg::A_IDLE;
        end else if (!dav_h) begin
          // lines are low-true: invert to get the byte
          r_next.lat = {!atn_h, !eoi_h, ~dio_h};
          r_next.push = 1'b1;
          r_next.nrfd_oe_n = 1'b0;
          r_next.acc = gpib_pkg::A_ACK;
        end
      end
      gpib_pkg::A_ACK: begin
        r_next.ndac_oe_n = 1'b1;
        r_next.acc = gpib_pkg::A_DONE;
      end
      gpib_pkg::A_DONE: begin
        if (dav_h) begin
          r_next.ndac_oe_n = 1'b0;
          r_next.acc = gpib_pkg::A_IDLE;
        end
      end
      default: begin
        r_next.acc = gpib_pkg::A_IDLE;
      end
    endcase
    // source handshake; the attention line is never driven here
    r_next.txr = 1'b0;
    case (r_reg.src)
      gpib_pkg::S_IDLE: begin
        r_next.txr = r_reg.tlk && atn_h && ifc_h;
        if (tx_valid && r_reg.txr) begin
          r_next.txr = 1'b0;
          r_next.dio_oe_n = ~tx_data;
          r_next.eoi_oe_n = !tx_end;
          r_next.cnt = gpib_pkg::SETTLE_LD;
          r_next.src = gpib_pkg::S_SET;
        end
      end
      gpib_pkg::S_SET: begin
        if (!atn_h) begin
          // controller took the bus back: drop the byte
          r_next.dio_oe_n = 8'hFF;
          r_next.eoi_oe_n = 1'b1;
          r_next.src = gpib_pkg::S_IDLE;
        end else if (r_reg.cnt != '0) begin
          r_next.cnt = r_reg.cnt - 1'b1;
        end else if (nrfd_h) begin
          r_next.dav_oe_n = 1'b0;
          r_next.src = gpib_pkg::S_DAV;
        end
      end
      gpib_pkg::S_DAV: begin
        if (ndac_h) begin
          r_next.dav_oe_n = 1'b1;
          r_next.cnt = gpib_pkg::SETTLE_LD;
          r_next.src = gpib_pkg::S_REL;
        end
      end
      gpib_pkg::S_REL: begin
        // data held a settle time past valid going away
        if (r_reg.cnt != '0) begin
          r_next.cnt = r_reg.cnt - 1'b1;
        end else begin
          r_next.dio_oe_n = 8'hFF;
          r_next.eoi_oe_n = 1'b1;
          r_next.src = gpib_pkg::S_IDLE;
        end
      end
      default: begin
        r_next.src = gpib_pkg::S_IDLE;
      end
    endcase
    // interface clear overrides addressing and both handshakes and frees every line except service request
    if (!ifc_h) begin
      r_next.lsn = 1'b0;
      r_next.tlk = 1'b0;
      r_next.spl = 1'b0;
      r_next.txr = 1'b0;
      r_next.push = 1'b0;
      r_next.acc = gpib_pkg::A_IDLE;
      r_next.src = gpib_pkg::S_IDLE;
      r_next.nrfd_oe_n = 1'b1;
      r_next.ndac_oe_n = 1'b1;
      r_next.dav_oe_n = 1'b1;
      r_next.eoi_oe_n = 1'b1;
      r_next.dio_oe_n = 8'hFF;
    end
  end

  // reset leaves the bus released and the port unaddressed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '{acc: gpib_pkg::A_IDLE, src: gpib_pkg::S_IDLE,
                 nrfd_oe_n: 1'b1, ndac_oe_n: 1'b1, dav_oe_n: 1'b1,
                 eoi_oe_n: 1'b1, srq_oe_n: 1'b1, dio_oe_n: 8'hFF,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dio_out = {8{r_reg.drv}};
  assign dio_oe_n = r_reg.dio_oe_n;
  assign dav_n_out = r_reg.drv;
  assign dav_oe_n = r_reg.dav_oe_n;
  assign nrfd_n_out = r_reg.drv;
  assign nrfd_oe_n = r_reg.nrfd_oe_n;
  assign ndac_n_out = r_reg.drv;
  assign ndac_oe_n = r_reg.ndac_oe_n;
  assign eoi_n_out = r_reg.drv;
  assign eoi_oe_n = r_reg.eoi_oe_n;
  assign srq_n_out = r_reg.drv;
  assign srq_oe_n = r_reg.srq_oe_n;
  assign rx_data = rx_word[7:0];
  assign rx_end = rx_word[8];
  assign rx_cmd = rx_word[9];
  assign tx_ready = r_reg.txr;
  assign listening = r_reg.lsn;
  assign talking = r_reg.tlk;
  assign spoll_on = r_reg.spl;
  assign remote = r_reg.rem;
  assign ppoll_req = r_reg.ppr;
  assign ifc_active = r_reg.ifca;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_load;
    (r_reg.src == gpib_pkg::S_SET) && ($past(r_reg.src) == gpib_pkg::S_IDLE);
  endsequence

  sequence s_latch;
    r_reg.push && (r_reg.acc == gpib_pkg::A_ACK);
  endsequence

  dav_ready_a: assert property ($fell(r_reg.dav_oe_n) |-> $past(nrfd_h))
    else $error("data valid asserted without ready");
  nrfd_room_a: assert property (
    $rose(r_reg.nrfd_oe_n) && r_reg.acc == gpib_pkg::A_READY |-> $past(buf_in_ready))
    else $error("ready released with no room");
  ndac_latch_a: assert property (s_latch |-> !r_reg.ndac_oe_n ##1 r_reg.ndac_oe_n)
    else $error("accepted not released after latch");
  data_invert_a: assert property (r_reg.push |-> r_reg.lat[7:0] == ~$past(dio_h))
    else $error("received byte not inverted");
  cmd_flag_a: assert property (r_reg.push |-> r_reg.lat[9] == !$past(atn_h))
    else $error("command flag does not follow attention");
  eoi_mark_a: assert property (s_load |-> r_reg.eoi_oe_n == !$past(tx_end))
    else $error("end line does not follow byte");
  ppoll_a: assert property (!atn_h && !eoi_h |=> ppoll_req)
    else $error("poll request missed");
  ifc_clear_a: assert property (
    !ifc_h |=> !r_reg.lsn && !r_reg.tlk && !r_reg.spl && r_reg.dav_oe_n)
    else $error("interface clear did not halt port");
  remote_a: assert property (!ren_h |=> remote)
    else $error("remote not shown");
  srq_a: assert property (srq_req |=> !srq_oe_n)
    else $error("service request not driven");
  release_a: assert property (
    $rose(r_reg.dav_oe_n) && ifc_h |-> $past(ndac_h) ##1 $stable(r_reg.dio_oe_n))
    else $error("data changed with valid or before accept");
endmodule : gpib_instrument_port
`default_nettype wire

// file: gpib_ctrl_model.sv
// behavioural controller in charge and peer device on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module gpib_ctrl_model (
  // clock
  input wire logic clk,
  // resolved wire levels
  input wire logic [7:0] dio_w,
  input wire logic dav_w,
  input wire logic nrfd_w,
  input wire logic ndac_w,
  input wire logic eoi_w,
  // pulls, high drags the line low
  output logic [7:0] dio_pl,
  output logic dav_pl,
  output logic nrfd_pl,
  output logic ndac_pl,
  output logic eoi_pl,
  output logic atn_pl,
  output logic ifc_pl,
  output logic ren_pl
);
  // ----------
  // idle: lines released, acceptor not ready
  // ----------
  initial begin
    {dio_pl, dav_pl, eoi_pl, atn_pl, ifc_pl, ren_pl} = '0;
    {nrfd_pl, ndac_pl} = 2'h3;
  end

  // wait for a handshake level; a bound keeps a dead bus from hanging us
  task automatic await(input int k, input logic v, inout logic ok);
    logic [2:0] h;
    int n;
    n = 0;
    h = {ndac_w, nrfd_w, dav_w};
    while (ok && h[k] !== v) begin
      @(posedge clk);
      h = {ndac_w, nrfd_w, dav_w};
      n++;
      if (n > 300) ok = 1'b0;
    end
  endtask : await

  // management lines, only this party drives attention
  task automatic lines(input logic a, e, i, r);
    @(posedge clk);
    atn_pl <= a;
    eoi_pl <= e;
    ifc_pl <= i;
    ren_pl <= r;
  endtask : lines

  // source one byte; cmd selects attention low
  task automatic send_byte(input logic [7:0] d, input logic cmd, e, output logic ok);
    ok = 1'b1;
    @(posedge clk);
    atn_pl <= cmd;
    {nrfd_pl, ndac_pl} <= 2'h0;
    dio_pl <= d; // a one pulls low
    eoi_pl <= e & ~cmd;
    repeat (3) @(posedge clk);
    await(1, 1'b1, ok);
    dav_pl <= 1'b1;
    await(2, 1'b1, ok);
    dav_pl <= 1'b0;
    @(posedge clk);
    {dio_pl, eoi_pl} <= '0; // data moves only after valid released
    {nrfd_pl, ndac_pl} <= 2'h3;
  endtask : send_byte

  // accept one byte from the instrument
  task automatic take_byte(output logic [7:0] d, output logic e, ok);
    ok = 1'b1;
    @(posedge clk);
    nrfd_pl <= 1'b0;
    await(0, 1'b0, ok);
    d = ~dio_w;
    e = ~eoi_w;
    nrfd_pl <= 1'b1;
    ndac_pl <= 1'b0; // only after the latch above
    await(0, 1'b1, ok);
    ndac_pl <= 1'b1;
  endtask : take_byte
endmodule : gpib_ctrl_model
`default_nettype wire

// file: tb.sv
// self-checking testbench for the instrument bus port
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk, nrst, rx_ready, tx_end, tx_valid, set_listen, set_talk, set_spoll, clr_addr;
  logic srq_req, tx_ready, listening, talking, spoll_on, remote, ppoll_req, ifc_active;
  logic [7:0] tx_data, rx_data, dio_out, dio_oe_n, dio_pl;
  logic dav_n_out, dav_oe_n, nrfd_n_out, nrfd_oe_n, ndac_n_out, ndac_oe_n, eoi_n_out;
  logic eoi_oe_n, srq_n_out, srq_oe_n, rx_cmd, rx_end, rx_valid;
  logic dav_pl, nrfd_pl, ndac_pl, eoi_pl, atn_pl, ifc_pl, ren_pl;
  int fail_count, checked;
  // ----------
  // open-drain wires with pull-ups
  // ----------
  wire [7:0] dio_w = ~(dio_pl | ~dio_oe_n);
  wire dav_w = ~(dav_pl | ~dav_oe_n);
  wire nrfd_w = ~(nrfd_pl | ~nrfd_oe_n);
  wire ndac_w = ~(ndac_pl | ~ndac_oe_n);
  wire eoi_w = ~(eoi_pl | ~eoi_oe_n);

  gpib_instrument_port dut (.clk, .nrst, .dio_in(dio_w), .dio_out, .dio_oe_n,
    .dav_n_in(dav_w), .dav_n_out, .dav_oe_n, .nrfd_n_in(nrfd_w), .nrfd_n_out, .nrfd_oe_n,
    .ndac_n_in(ndac_w), .ndac_n_out, .ndac_oe_n, .eoi_n_in(eoi_w), .eoi_n_out, .eoi_oe_n,
    .atn_n_in(~atn_pl), .ifc_n_in(~ifc_pl), .ren_n_in(~ren_pl), .srq_n_out, .srq_oe_n,
    .rx_data, .rx_cmd, .rx_end, .rx_valid, .rx_ready, .tx_data, .tx_end, .tx_valid,
    .tx_ready, .set_listen, .set_talk, .set_spoll, .clr_addr, .srq_req, .listening,
    .talking, .spoll_on, .remote, .ppoll_req, .ifc_active);

  gpib_ctrl_model pm (.clk, .dio_w, .dav_w, .nrfd_w, .ndac_w, .eoi_w, .dio_pl, .dav_pl,
    .nrfd_pl, .ndac_pl, .eoi_pl, .atn_pl, .ifc_pl, .ren_pl);

  // ----------
  // compare and closing tasks
  // ----------
  task automatic chk1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk1

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic wrap_up();
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // one-cycle pulse on the strobes: bit 0 listen, 1 talk, 2 serial poll, 3 clear
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    {clr_addr, set_spoll, set_talk, set_listen} <= m;
    @(posedge clk);
    {clr_addr, set_spoll, set_talk, set_listen} <= 4'h0;
  endtask : pulse

  // wait for a received word, judge it, pop it
  task automatic pop(input logic [7:0] d, input logic c, e);
    for (int n = 0; n < 100 && rx_valid !== 1'b1; n++) begin
      @(posedge clk);
    end
    chk1("rx_valid", 1'b1, rx_valid);
    chk8("rx_data", d, rx_data);
    chk1("rx_cmd", c, rx_cmd);
    chk1("rx_end", e, rx_end);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    @(posedge clk);
  endtask : pop

  // ----------
  // scenarios
  // ----------
  // two data bytes fill the buffer, a stalled reader holds not-ready low
  task automatic listen_rx();
    logic ok;
    pulse(4'h1);
    repeat (2) @(posedge clk);
    pm.send_byte(8'hA5, 1'b0, 1'b0, ok);
    chk1("hs_a", 1'b1, ok);
    pm.send_byte(8'h3C, 1'b0, 1'b1, ok);
    chk1("hs_b", 1'b1, ok);
    repeat (30) @(posedge clk);
    chk1("nrfd_full", 1'b0, nrfd_oe_n);
    pop(8'hA5, 1'b0, 1'b0);
    pop(8'h3C, 1'b0, 1'b1);
    pm.send_byte(8'h14, 1'b1, 1'b0, ok);
    chk1("hs_c", 1'b1, ok);
    pop(8'h14, 1'b1, 1'b0);
    chk1("rx_empty", 1'b0, rx_valid);
    pm.lines(1'b0, 1'b0, 1'b0, 1'b0);
  endtask : listen_rx

  // talker waits for ready acceptors, then hands over one end-marked byte
  task automatic talk_tx();
    logic ok, e;
    logic [7:0] d;
    pulse(4'h8);
    pulse(4'h2);
    for (int n = 0; n < 50 && tx_ready !== 1'b1; n++) begin
      @(posedge clk);
    end
    chk1("tx_ready", 1'b1, tx_ready);
    chk1("talking", 1'b1, talking);
    tx_data <= 8'h96;
    tx_end <= 1'b1;
    tx_valid <= 1'b1;
    @(posedge clk);
    tx_valid <= 1'b0;
    repeat (25) @(posedge clk);
    chk1("dav_early", 1'b1, dav_oe_n);
    pm.take_byte(d, e, ok);
    chk8("tx_byte", 8'h96, d);
    chk1("tx_end", 1'b1, e);
    chk1("hs_t", 1'b1, ok);
    repeat (20) @(posedge clk);
    chk8("dio_free", 8'hFF, dio_oe_n);
    // second byte: attention taken back during settle must drop it
    tx_data <= 8'h5A;
    tx_end <= 1'b0;
    tx_valid <= 1'b1;
    @(posedge clk);
    tx_valid <= 1'b0;
    @(posedge clk);
    chk8("dio_load", 8'hA5, dio_oe_n);
    chk1("eoi_load", 1'b1, eoi_oe_n);
    pm.lines(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (5) @(posedge clk);
    chk8("dio_abort", 8'hFF, dio_oe_n);
    chk1("dav_abort", 1'b1, dav_oe_n);
    pm.lines(1'b0, 1'b0, 1'b0, 1'b0);
  endtask : talk_tx

  // poll request, remote, service request, then interface clear
  task automatic mgmt();
    pm.lines(1'b1, 1'b1, 1'b0, 1'b1);
    srq_req <= 1'b1;
    pulse(4'h1);
    pulse(4'h4);
    repeat (5) @(posedge clk);
    chk1("ppoll_req", 1'b1, ppoll_req);
    chk1("remote", 1'b1, remote);
    chk1("srq_on", 1'b0, srq_oe_n);
    chk1("spoll_set", 1'b1, spoll_on);
    pm.lines(1'b0, 1'b0, 1'b1, 1'b0);
    srq_req <= 1'b0;
    repeat (6) @(posedge clk);
    chk1("ifc_active", 1'b1, ifc_active);
    chk1("unlisten", 1'b0, listening);
    chk1("spoll_off", 1'b0, spoll_on);
    chk1("local", 1'b0, remote);
    chk1("srq_off", 1'b1, srq_oe_n);
    chk1("untalk", 1'b0, talking);
    chk8("dio_out", 8'h00, dio_out);
    chk8("od_low", 8'h00, {3'h0, dav_n_out, nrfd_n_out, ndac_n_out, eoi_n_out, srq_n_out});
    pm.lines(1'b0, 1'b0, 1'b0, 1'b0);
  endtask : mgmt

  // ----------
  // clock, main sequence, watchdog
  // ----------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    nrst = 1'b0;
    {rx_ready, tx_data, tx_end, tx_valid, set_listen, set_talk} = '0;
    {set_spoll, clr_addr, srq_req} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    listen_rx();
    talk_tx();
    mgmt();
    wrap_up();
  end

  // whole run needs well under a thousand cycles; this margin catches a hang
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
